// >>> nexh_pkg.sv
package nexh_pkg;
	// Exception class positions in flag and mask words
	localparam int EXC_INVALID = 0;
	localparam int EXC_ZERODIV = 1;
	localparam int EXC_DENORM = 2;
	localparam int EXC_OVERFLOW = 3;
	localparam int EXC_UNDERFLOW = 4;
	localparam int EXC_INEXACT = 5;
	localparam int EXC_COUNT = 6;
	localparam logic [5:0] FLAGS_RESET = 6'h00;
	localparam logic [5:0] MASK_RESET = 6'h3F;
	// Condition code positions
	localparam int CC_ZERO = 0;
	localparam int CC_ONE = 1;
	localparam int CC_TWO = 2;
	localparam int CC_THREE = 3;
	localparam logic [3:0] CC_UNORDERED = 4'hD;
	localparam logic [3:0] CC_RESET = 4'h0;
	// Special values, extended real: sign, exponent 15, significand 64
	localparam logic [79:0] QNAN_INDEFINITE = 80'hFFFF_C000_0000_0000_0000;
	localparam logic [79:0] NEG_INFINITY = 80'hFFFF_8000_0000_0000_0000;
	localparam logic [79:0] POS_INFINITY = 80'h7FFF_8000_0000_0000_0000;
	localparam logic [63:0] INTEGER_INDEFINITE = 64'h8000_0000_0000_0000;
	// Sign 1, seven ones, two digits of ones; low digits left zero
	localparam logic [79:0] DECIMAL_INDEFINITE = 80'hFFFF_0000_0000_0000_0000;
	localparam logic [79:0] VALUE_RESET = 80'h0;

	typedef enum logic [4:0] {
		NEXH_NONE = 5'h00,
		NEXH_DIVIDE = 5'h01,
		NEXH_LOG = 5'h02,
		NEXH_SPLIT = 5'h03,
		NEXH_REMAINDER = 5'h04,
		NEXH_TRIG = 5'h05,
		NEXH_COMPARE = 5'h06,
		NEXH_INT_STORE = 5'h07,
		NEXH_DEC_STORE = 5'h08,
		NEXH_EXCHANGE = 5'h09,
		NEXH_ARITH = 5'h0A
	} nexh_op_t;

	// One instruction's reported conditions from the datapath
	typedef struct packed {
		logic valid;
		nexh_op_t op;
		logic stack_overflow;
		logic stack_underflow;
		logic invalid_operand;
		logic signalling_nan;
		logic zero_divide;
		logic denormal;
		logic overflow;
		logic underflow;
		logic inexact;
		logic sign_a;
		logic sign_b;
		logic [79:0] nan_quieted;
		logic head_empty;
		logic second_empty;
	} nexh_event_t;

	// Software side of the status and control words
	typedef struct packed {
		logic clear_exceptions_op;
		logic reinit;
		logic restore_state_op;
		logic [5:0] restore_flags;
		logic restore_sf;
		logic [3:0] restore_cc;
		logic mask_write;
		logic [5:0] mask_value;
	} nexh_ctrl_t;

	// Fix-up results returned to the datapath
	typedef struct packed {
		logic valid;
		logic commit;
		logic write_head;
		logic [79:0] head_value;
		logic write_second;
		logic [79:0] second_value;
		logic write_memory;
		logic [79:0] memory_value;
		logic exchange;
	} nexh_result_t;
endpackage : nexh_pkg

// >>> nexh_handler.sv
`timescale 1ns/1ps
// Contract
// - Six exception classes each own a flag bit and a mask bit.
// - Masked exception applies its default result and computation continues.
// - Unmasked exception drives the error request toward the host.
// - Masked responses continue, so one instruction may set several flags.
// - Flags sticky; cleared only by clear, reinit, or restore overwrite.
// - Stack fault flag is 1 for stack faults, 0 for bad operands.
// - Condition code one is 1 for overflow, 0 for underflow.
// - Masked stack fault writes quiet-NaN indefinite to destination.
// - Unmasked stack fault signals host, keeps head index and sources.
// - Unmasked invalid arithmetic signals host and modifies no operand.
// - Listed invalid arithmetic cases return quiet-NaN indefinite when masked.
// - Signalling NaN operand raises invalid; masked result is a quiet NaN.
// - NaN in compare or test raises invalid; masked sets unordered codes.
// - Bad remainder or infinite trig argument returns indefinite, sets code two.
// - Bad integer store raises invalid; masked stores integer indefinite.
// - Bad decimal store raises invalid; masked stores decimal indefinite.
// - Exchange with empty register raises invalid; masked fills indefinite, exchanges.
// - Finite nonzero divided by zero raises divide-by-zero, also log and split.
// - Masked zero divide in divide or log returns infinity, sign xor.
// - Masked zero divide in split: second minus infinity, head signed zero.
// - Unmasked zero divide signals host and leaves operands unchanged.
// - Classes: invalid, divide-by-zero, denormal, overflow, underflow, inexact.
// - Decimal indefinite: sign 1, seven ones, two digits of ones.
module nexh_handler
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire nexh_pkg::nexh_event_t i_event,
	input wire nexh_pkg::nexh_ctrl_t i_ctrl,
	output nexh_pkg::nexh_result_t o_result,
	output logic [5:0] o_flags,
	output logic [5:0] o_mask,
	output logic o_stack_fault_flag,
	output logic [3:0] o_cc,
	output logic o_error_req
);
	import nexh_pkg::*;

	typedef struct packed {
		logic [5:0] flags;
		logic [5:0] mask;
		logic sf;
		logic [3:0] cc;
		logic err;
		nexh_result_t res;
	} nexh_state_t;

	nexh_state_t state_reg;
	nexh_state_t state_next;
	logic [5:0] raised;
	logic stack_fault;
	logic inv_arith;
	logic inv_masked;
	logic zd_masked;
	logic [5:0] flags_after;
	logic [5:0] mask_after;
	logic zd_sign;

	always_comb
	begin
		nexh_event_t e;
		e = i_event;
		stack_fault = e.valid && (e.stack_overflow || e.stack_underflow);
		inv_arith = e.valid && (e.invalid_operand || e.signalling_nan);
		raised = '0;
		// Every class is recorded; masked ones do not abort the instruction
		raised[EXC_INVALID] = stack_fault || inv_arith;
		raised[EXC_ZERODIV] = e.valid && e.zero_divide;
		raised[EXC_DENORM] = e.valid && e.denormal;
		raised[EXC_OVERFLOW] = e.valid && e.overflow;
		raised[EXC_UNDERFLOW] = e.valid && e.underflow;
		raised[EXC_INEXACT] = e.valid && e.inexact;
		zd_sign = e.sign_a ^ e.sign_b;

		state_next = state_reg;
		state_next.res = '0;
		mask_after = i_ctrl.mask_write ? i_ctrl.mask_value : state_reg.mask;

		// Clears act first so a same-cycle event is never lost
		flags_after = state_reg.flags;
		if (i_ctrl.reinit)
		begin
			flags_after = FLAGS_RESET;
			mask_after = MASK_RESET;
			state_next.sf = 1'b0;
			state_next.cc = CC_RESET;
		end
		else if (i_ctrl.restore_state_op)
		begin
			flags_after = i_ctrl.restore_flags;
			state_next.sf = i_ctrl.restore_sf;
			state_next.cc = i_ctrl.restore_cc;
		end
		else if (i_ctrl.clear_exceptions_op)
		begin
			flags_after = FLAGS_RESET;
			state_next.sf = 1'b0;
		end
		flags_after = flags_after | raised;
		state_next.flags = flags_after;
		state_next.mask = mask_after;
		// Taken after reinit so trap choice matches the mask that is stored
		inv_masked = mask_after[EXC_INVALID];
		zd_masked = mask_after[EXC_ZERODIV];

		if (stack_fault)
		begin
			state_next.sf = 1'b1;
			state_next.cc[CC_ONE] = e.stack_overflow;
		end
		else if (inv_arith)
			state_next.sf = 1'b0;

		if (e.valid)
		begin
			state_next.res.valid = 1'b1;
			state_next.res.commit = 1'b1;
			if (raised[EXC_INVALID] && !inv_masked)
				// Operands and head index stay untouched for the trap handler
				state_next.res.commit = 1'b0;
			else if (raised[EXC_ZERODIV] && !zd_masked)
				state_next.res.commit = 1'b0;
			else if (stack_fault)
			begin
				state_next.res.write_head = 1'b1;
				state_next.res.head_value = QNAN_INDEFINITE;
			end
			else if (inv_arith)
			begin
				unique case (e.op)
					NEXH_COMPARE:
						state_next.cc = CC_UNORDERED;
					NEXH_INT_STORE:
					begin
						state_next.res.write_memory = 1'b1;
						state_next.res.memory_value = {16'h0000, INTEGER_INDEFINITE};
					end
					NEXH_DEC_STORE:
					begin
						state_next.res.write_memory = 1'b1;
						state_next.res.memory_value = DECIMAL_INDEFINITE;
					end
					NEXH_EXCHANGE:
					begin
						state_next.res.exchange = 1'b1;
						state_next.res.write_head = e.head_empty;
						state_next.res.head_value = QNAN_INDEFINITE;
						state_next.res.write_second = e.second_empty;
						state_next.res.second_value = QNAN_INDEFINITE;
					end
					NEXH_REMAINDER, NEXH_TRIG:
					begin
						state_next.res.write_head = 1'b1;
						state_next.res.head_value = QNAN_INDEFINITE;
						state_next.cc[CC_TWO] = 1'b1;
					end
					default:
					begin
						state_next.res.write_head = 1'b1;
						if (e.signalling_nan)
							state_next.res.head_value = e.nan_quieted;
						else
							state_next.res.head_value = QNAN_INDEFINITE;
					end
				endcase
			end
			else if (raised[EXC_ZERODIV])
			begin
				state_next.res.write_head = 1'b1;
				if (e.op == NEXH_SPLIT)
				begin
					state_next.res.write_second = 1'b1;
					state_next.res.second_value = NEG_INFINITY;
					state_next.res.head_value = {e.sign_a, 79'h0};
				end
				else
					state_next.res.head_value = zd_sign ? NEG_INFINITY : POS_INFINITY;
			end
		end

		// Level follows unmasked sticky flags; host samples at its own pace
		state_next.err = |(flags_after & ~mask_after);
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_srst)
		begin
			state_reg <= '0;
			state_reg.mask <= MASK_RESET;
			state_reg.flags <= FLAGS_RESET;
		end
		else
			state_reg <= state_next;
	end

	assign o_result = state_reg.res;
	assign o_flags = state_reg.flags;
	assign o_mask = state_reg.mask;
	assign o_stack_fault_flag = state_reg.sf;
	assign o_cc = state_reg.cc;
	assign o_error_req = state_reg.err;
endmodule : nexh_handler

// >>> nexh_handler_assertions.sv
`timescale 1ns/1ps
module nexh_handler_assertions
(
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire nexh_pkg::nexh_event_t i_event,
	input wire nexh_pkg::nexh_ctrl_t i_ctrl,
	input wire nexh_pkg::nexh_result_t o_result,
	input wire logic [5:0] o_flags,
	input wire logic [5:0] o_mask,
	input wire logic o_stack_fault_flag,
	input wire logic [3:0] o_cc,
	input wire logic o_error_req
);
	import nexh_pkg::*;
	logic quiet;
	logic inv;
	assign quiet = !(i_ctrl.clear_exceptions_op | i_ctrl.reinit | i_ctrl.restore_state_op
		| i_ctrl.mask_write);
	assign inv = i_event.stack_overflow | i_event.stack_underflow | i_event.invalid_operand
		| i_event.signalling_nan;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	property p_valid;
		i_event.valid |=> o_result.valid;
	endproperty
	a_valid: assert property (p_valid) else $error("result valid missing");
	property p_trap;
		i_event.valid && i_event.zero_divide && !o_mask[1] && quiet
			|=> o_error_req && !o_result.commit;
	endproperty
	a_trap: assert property (p_trap) else $error("unmasked zero divide");
	property p_sticky;
		quiet |=> (o_flags & $past(o_flags)) == $past(o_flags);
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag lost");
	property p_clear;
		i_ctrl.clear_exceptions_op && !i_ctrl.reinit && !i_ctrl.restore_state_op
			&& !i_event.valid |=> o_flags == 6'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("clear failed");
	property p_err;
		quiet && !i_event.valid |=> o_error_req == |(o_flags & ~o_mask);
	endproperty
	a_err: assert property (p_err) else $error("error level wrong");
	property p_sf;
		i_event.valid && (i_event.stack_overflow | i_event.stack_underflow) && quiet
			|=> o_stack_fault_flag && o_cc[1] == $past(i_event.stack_overflow);
	endproperty
	a_sf: assert property (p_sf) else $error("stack fault codes");
	property p_nan;
		i_event.valid && i_event.op == NEXH_ARITH && i_event.stack_underflow && o_mask[0]
			&& quiet |=> o_result.commit && o_result.head_value == QNAN_INDEFINITE;
	endproperty
	a_nan: assert property (p_nan) else $error("no indefinite");
	property p_div;
		i_event.valid && i_event.op == NEXH_DIVIDE && i_event.zero_divide && !inv
			&& o_mask[1] && quiet |=> o_result.head_value
			== ($past(i_event.sign_a ^ i_event.sign_b) ? NEG_INFINITY : POS_INFINITY);
	endproperty
	a_div: assert property (p_div) else $error("infinity wrong");
endmodule : nexh_handler_assertions
bind nexh_handler nexh_handler_assertions nexh_handler_assertions_inst (.i_sys_clk(i_sys_clk),
	.i_srst(i_srst), .i_event(i_event), .i_ctrl(i_ctrl), .o_result(o_result),
	.o_flags(o_flags), .o_mask(o_mask), .o_stack_fault_flag(o_stack_fault_flag),
	.o_cc(o_cc), .o_error_req(o_error_req));

// >>> nexh_host.sv
`timescale 1ns/1ps
module nexh_host
(
	input wire logic i_sys_clk,
	input wire logic i_error_req,
	input wire logic i_wait_op,
	output logic o_trap,
	output logic [7:0] o_vector
);
	// Error is only looked at on a wait, never between instructions
	always_ff @(posedge i_sys_clk)
	begin
		o_trap <= i_wait_op & i_error_req;
		o_vector <= 8'h10;
	end
endmodule : nexh_host

// >>> nexh_handler_test.sv
`timescale 1ns/1ps
module nexh_handler_test;
	import nexh_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic wt = 0;
	nexh_event_t ev = '0;
	nexh_ctrl_t ct = '0;
	nexh_result_t res;
	logic [5:0] fl;
	logic [5:0] mk;
	logic sf;
	logic er;
	logic trap;
	logic [3:0] cc;
	logic [7:0] vec;
	int err_count = 0;
	int checked = 0;
	int cyc = 0;
	nexh_handler nexh_handler_inst (.i_sys_clk(clk), .i_srst(rst), .i_event(ev), .i_ctrl(ct),
		.o_result(res), .o_flags(fl), .o_mask(mk), .o_stack_fault_flag(sf), .o_cc(cc),
		.o_error_req(er));
	nexh_host nexh_host_inst (.i_sys_clk(clk), .i_error_req(er), .i_wait_op(wt),
		.o_trap(trap), .o_vector(vec));
	initial
	begin
		forever #4 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 1000)
		begin
			err_count++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [79:0] g, input logic [79:0] e);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	// Bits: ovf unf inv snan zdiv den ovr und inx sign_a sign_b
	function automatic nexh_event_t mkev(input nexh_op_t op, input logic [10:0] b);
		return {1'b1, op, b, 80'h0, 2'b00};
	endfunction : mkev
	// Outputs are registered, so the next falling edge sees the answer
	task automatic go(input nexh_event_t e, input nexh_ctrl_t c);
		@(negedge clk);
		ev = e;
		ct = c;
		@(negedge clk);
		ev = '0;
		ct = '0;
	endtask : go
	task automatic t_div;
		go(mkev(NEXH_DIVIDE, 11'h042), '0);
		chk(res.head_value, NEG_INFINITY);
		chk({res.commit, fl[1], er}, 3'b110);
		go(mkev(NEXH_SPLIT, 11'h042), 21'h100000);
		chk(res.second_value, NEG_INFINITY);
		chk(res.head_value, {1'b1, 79'h0});
		$display("t_div done");
	endtask : t_div
	task automatic t_trap;
		go('0, {14'h0, 1'b1, 6'h3D});
		go(mkev(NEXH_DIVIDE, 11'h040), '0);
		chk({res.valid, res.commit, res.write_head, er, fl[1]}, 5'h13);
		wt = 1;
		@(negedge clk);
		wt = 0;
		chk({trap, vec}, 9'h110);
		go('0, 21'h100000);
		@(negedge clk);
		chk({fl, er}, 7'h00);
		go('0, {14'h0, 1'b1, 6'h3F});
		$display("t_trap done");
	endtask : t_trap
	task automatic t_stack;
		go(mkev(NEXH_ARITH, 11'h200), '0);
		chk(res.head_value, QNAN_INDEFINITE);
		chk({sf, cc[1], fl[0]}, 3'b101);
		go(mkev(NEXH_ARITH, 11'h400), '0);
		chk(cc[1], 1'b1);
		$display("t_stack done");
	endtask : t_stack
	task automatic t_multi;
		go(mkev(NEXH_ARITH, 11'h028), 21'h100000);
		go('0, '0);
		chk(fl, 6'h14);
		go('0, 21'h080000);
		chk({fl, mk, cc}, 16'h03F0);
		$display("t_multi done");
	endtask : t_multi
	task automatic t_inv;
		go(mkev(NEXH_TRIG, 11'h100), '0);
		chk({res.head_value[79:62], cc[2], sf}, 20'hFFFFE);
		go(mkev(NEXH_COMPARE, 11'h100), '0);
		chk(cc, CC_UNORDERED);
		go(mkev(NEXH_DEC_STORE, 11'h100), '0);
		chk(res.memory_value, DECIMAL_INDEFINITE);
		go(mkev(NEXH_INT_STORE, 11'h100), '0);
		chk(res.memory_value[63:0], INTEGER_INDEFINITE);
		$display("t_inv done");
	endtask : t_inv
	task automatic t_more;
		nexh_event_t e;
		e = mkev(NEXH_EXCHANGE, 11'h100);
		e.head_empty = 1'b1;
		go(e, '0);
		chk({res.exchange, res.write_head, res.write_second}, 3'b110);
		chk(res.head_value, QNAN_INDEFINITE);
		e = mkev(NEXH_ARITH, 11'h080);
		e.nan_quieted = 80'h7FFF_C000_0000_0000_1234;
		go(e, '0);
		chk(res.head_value, 80'h7FFF_C000_0000_0000_1234);
		go('0, {14'h0, 1'b1, 6'h3E});
		go(mkev(NEXH_ARITH, 11'h100), '0);
		chk({res.valid, res.commit, res.write_head, er}, 4'b1001);
		go('0, 21'h080000);
		chk({fl, mk, er}, 13'h07E);
		$display("t_more done");
	endtask : t_more
	initial
	begin
		repeat (8) @(negedge clk);
		rst = 0;
		chk({fl, mk, sf, cc, er}, {6'h00, 6'h3F, 6'h00});
		t_div;
		t_trap;
		t_stack;
		t_multi;
		t_inv;
		t_more;
		tally_and_finish;
	end
endmodule : nexh_handler_test
